// *** bench/lsba_align_bench.sv ***
// Self-checking bench of the load/store byte lane alignment datapath.
`timescale 1ns/1ps

module lsba_align_bench;
  import lsba_pkg::*;
  logic clk, rstn, user, rev, big;
  logic [31:0] reg_old, mem_data, seed, fwd_w;
  logic [31:0] cycles = 32'h0;
  lsba_req_type req;
  lsba_bus_type o_bus;
  lsba_wb_type o_wb;
  logic addr_err;
  int errors = 0;
  int checks_done = 0;
  lsba_op_type ops [13] = '{load_byte_signed, load_byte_unsigned,
    load_half_signed, load_half_unsigned, load_word_full,
    load_word_left_part, load_word_right_part, store_byte_op, store_half_op,
    store_word_full, store_word_left_part, store_word_right_part, op_none};

  // =========================================================
  // Instances
  lsba_align u_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_req(req),
    .i_reg_old(reg_old), .i_user_mode(user), .i_reverse_endian_user(rev),
    .i_big_endian(big), .i_mem_data(mem_data), .o_bus(o_bus),
    .o_addr_err(addr_err), .o_wb(o_wb));
  lsba_mem_model u_mem (.i_ref_clk(clk), .i_bus(o_bus),
    .o_mem_data(mem_data));

  // =========================================================
  // Helpers
  // Fixed-seed xorshift source.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Lane mask, legality and size code expected for an access.
  function automatic logic [3:0] lanes(input lsba_op_type op,
      input logic [1:0] ofs, input logic bg, output logic ok,
      output logic [1:0] sz);
    logic [1:0] ln;
    ln = bg ? 2'h3 - ofs : ofs;
    ok = 1'b1;
    sz = 2'h0;
    lanes = 4'h1 << ln;
    case (op)
      load_half_signed, load_half_unsigned, store_half_op: begin
        ok = !ofs[0];
        sz = 2'h1;
        lanes = 4'h3 << (ofs ^ (bg ? 2'h2 : 2'h0));
      end
      load_word_full, store_word_full: begin
        ok = (ofs == 2'h0);
        sz = 2'h3;
        lanes = 4'hf;
      end
      load_word_left_part, store_word_left_part: begin
        sz = ln;
        lanes = 4'((5'h2 << ln) - 5'h1);
      end
      load_word_right_part, store_word_right_part: begin
        sz = 2'h3 - ln;
        lanes = 4'hf << ln;
      end
      load_byte_signed, load_byte_unsigned, store_byte_op: ;
      default: ok = 1'b0;
    endcase
  endfunction

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Issues one request, then checks the bus access and the write-back.
  task automatic run_op(input lsba_op_type op, input logic [31:0] base,
      input logic [15:0] off, input logic [31:0] rd, input logic [31:0] old,
      input logic [2:0] md);
    logic [31:0] ad, w, m32, ev;
    logic bg, ok;
    logic [1:0] sz, ln, hl;
    logic [3:0] m;
    ad = base + {{16{off[15]}}, off};
    bg = md[0] ^ (md[1] & md[2]);
    m = lanes(op, ad[1:0], bg, ok, sz);
    ln = bg ? 2'h3 - ad[1:0] : ad[1:0];
    hl = ad[1:0] ^ (bg ? 2'h2 : 2'h0);
    m32 = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    @(posedge clk);
    req <= '{1'b1, op, base, off, rd, ad[6:2]};
    reg_old <= old;
    {rev, user, big} <= md;
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    w = mem_data;
    check(o_bus.valid, ok);
    check(addr_err, !ok);
    check(o_bus.byte_enable_lanes_n, ok ? 4'(~m) : 4'hf);
    if (ok) begin
      check(o_bus.addr, ad);
      check(o_bus.size, sz);
      check(o_bus.write, op[3]);
      case (op)
        store_word_full: ev = rd;
        store_half_op: ev = rd << (8 * hl);
        store_word_left_part: ev = rd >> (8 * (3 - ln));
        default: ev = rd << (8 * ln);
      endcase
      if (op[3]) check(o_bus.wdata & m32, ev & m32);
    end
    case (op)
      load_byte_signed: ev = {{24{w[8*ln+7]}}, 8'(w >> (8 * ln))};
      load_byte_unsigned: ev = {24'h0, 8'(w >> (8 * ln))};
      load_half_signed: ev = {{16{w[8*hl+15]}}, 16'(w >> (8 * hl))};
      load_half_unsigned: ev = {16'h0, 16'(w >> (8 * hl))};
      load_word_left_part: ev = (w << (8 * (3 - ln))) |
        (old & (32'hffff_ffff >> (8 * (ln + 1))));
      load_word_right_part: ev = (w >> (8 * ln)) |
        (old & ~(32'hffff_ffff >> (8 * ln)));
      default: ev = w;
    endcase
    @(posedge clk);
    #1;
    check(o_wb.valid, ok && !op[3]);
    if (ok && !op[3]) begin
      check(o_wb.dest, ad[6:2]);
      check(o_wb.data, ev);
    end
  endtask

  // =========================================================
  // Clock and timeout
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cuts a hang short well above the expected run length.
  always @(posedge clk) begin
    cycles <= cycles + 32'h1;
    if (cycles == 32'd6000) begin
      errors++;
      report_and_stop();
    end
  end

  // =========================================================
  // Main sequence
  initial begin
    seed = 32'h5550;
    rstn = 1'b0;
    req = '0;
    reg_old = 32'h0;
    {user, rev, big} = 3'h0;
    repeat (20) @(posedge clk);
    #1;
    check(o_bus.byte_enable_lanes_n, 4'hf);
    check({o_bus.valid, addr_err, o_wb.valid}, 3'h0);
    @(posedge clk);
    rstn <= 1'b1;
    // Every op at every offset in every endian mode.
    for (int i = 0; i < 13; i++) begin
      for (int j = 0; j < 32; j++) begin
        run_op(ops[i], 32'h0000_1000, 16'(j[1:0]), rnd(), rnd(), 3'(j >> 2));
      end
    end
    // Negative offset and address wrap.
    run_op(load_word_full, 32'h0000_0010, 16'h8000, 32'h0, 32'h0, 3'h0);
    run_op(load_half_signed, 32'hffff_fffe, 16'h0004, 32'h0, 32'h0, 3'h1);
    // A left load right behind a word load to the same register merges
    // into the forwarded word, not into the stale register value.
    @(posedge clk);
    req <= '{1'b1, load_word_full, 32'h0000_2000, 16'h0, 32'h0, 5'h07};
    {rev, user, big} <= 3'h0;
    @(posedge clk);
    req.op <= load_word_left_part;
    reg_old <= 32'hdead_beef;
    #1;
    fwd_w = mem_data;
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    check(o_wb.data, fwd_w);
    @(posedge clk);
    #1;
    check(o_wb.data, {fwd_w[7:0], fwd_w[23:0]});
    // Random traffic.
    for (int k = 0; k < 400; k++) begin
      run_op(ops[rnd() % 13], rnd(), 16'(rnd()), rnd(), rnd(), 3'(rnd()));
    end
    report_and_stop();
  end
endmodule

// *** bench/lsba_mem_model.sv ***
// Memory bus partner model that answers reads of the alignment datapath.
`timescale 1ns/1ps

module lsba_mem_model (
  input wire logic i_ref_clk, // Processor clock.
  input wire lsba_pkg::lsba_bus_type i_bus, // Access from the datapath.
  output logic [31:0] o_mem_data // Read data toward the datapath.
);
  import lsba_pkg::*;
  logic [31:0] last = 32'h0;

  // =========================================================
  // Read data
  // A read is answered in its own cycle with an address hash; otherwise
  // the lines flip each cycle so stale data is never mistaken for good.
  always_comb begin
    if (i_bus.valid && !i_bus.write) begin
      o_mem_data = (i_bus.addr * 32'h9e37_79b1) ^ 32'h1234_5678;
    end else begin
      o_mem_data = ~last;
    end
  end

  // Remembers the last value shown.
  always @(posedge i_ref_clk) begin
    last <= o_mem_data;
  end
endmodule

// *** rtl/lsba_align.sv ***
// Load/store address, byte lane and data alignment datapath.
// Functional notes
// - Transfer size decoded from load/store opcode.
// - Address is the effective address, not the lowest byte for left/right.
// - Reverse bit flips user-mode byte order.
// - Little-endian lane enables follow fixed table.
// - Illegal size/offset pairs never reach bus.
// - Four active-low byte enables, one per lane.
// - Address is base plus sign-extended offset.
// - Signed byte/half loads sign-extend.
// - Unsigned byte/half loads zero-extend.
// - Word load writes full word unchanged.
// - Left/right loads align addressed byte.
// - Partial loads keep unloaded register bytes.
// - Stores write low byte, half or word.
// - Store-left shifts right, writes original bytes.
// - Store-right shifts left, writes original bytes.
// - Load result ready second instruction later.
`timescale 1ns/1ps
`include "lsba_defs.svh"

module lsba_align (
  input wire logic i_ref_clk, // 200 MHz clock.
  input wire logic i_rstn, // Asynchronous reset, active low.
  input wire lsba_pkg::lsba_req_type i_req, // Access request.
  input wire logic [31:0] i_reg_old, // Destination value before load.
  input wire logic i_user_mode, // Request comes from user mode.
  input wire logic i_reverse_endian_user, // Reverse user byte order.
  input wire logic i_big_endian, // Kernel byte order is big-endian.
  input wire logic [31:0] i_mem_data, // Read data for bus access.
  output lsba_pkg::lsba_bus_type o_bus, // Registered bus access.
  output logic o_addr_err, // Illegal size/offset pulse.
  output lsba_pkg::lsba_wb_type o_wb // Registered load result.
);
  import lsba_pkg::*;

  // ==========================================================
  // Issue stage
  // ==========================================================
  logic [31:0] ea;
  logic big;
  logic [1:0] ofs;
  logic [1:0] lane;
  logic [1:0] hlane;
  logic is_load;
  logic legal;
  lsba_size_type size;
  logic [3:0] mask;
  logic [31:0] wdata;
  lsba_bus_type next_bus;
  logic next_err;
  lsba_op_type s1_op;
  lsba_op_type next_s1_op;
  logic [1:0] s1_lane;
  logic [1:0] next_s1_lane;
  logic [1:0] s1_hlane;
  logic [1:0] next_s1_hlane;
  logic [4:0] s1_dest;
  logic [4:0] next_s1_dest;
  logic [31:0] s1_old;
  logic [31:0] next_s1_old;

  // Address, byte order, lanes and store data of the new request.
  always_comb begin
    ea = i_req.base + {{16{i_req.offset[15]}}, i_req.offset};
    big = i_big_endian ^ (i_reverse_endian_user & i_user_mode);
    ofs = ea[1:0];
    lane = big ? ~ofs : ofs;
    hlane = ofs ^ (big ? `LSBA_HALF_SWAP : 2'h0);
    is_load = !i_req.op[3];
    legal = 1'b1;
    size = size_word;
    mask = `LSBA_MASK_FULL;
    wdata = i_req.data_reg;
    unique case (i_req.op)
      load_byte_signed, load_byte_unsigned, store_byte_op: begin
        size = size_byte;
        mask = `LSBA_MASK_BYTE << lane;
        wdata = i_req.data_reg << {lane, 3'h0};
      end
      load_half_signed, load_half_unsigned, store_half_op: begin
        size = size_half;
        legal = !ofs[0];
        mask = `LSBA_MASK_HALF << hlane;
        wdata = i_req.data_reg << {hlane, 3'h0};
      end
      load_word_full, store_word_full: begin
        legal = (ofs == 2'h0);
      end
      load_word_left_part, store_word_left_part: begin
        size = lsba_size_type'(lane);
        mask = `LSBA_MASK_FULL >> ~lane;
        wdata = i_req.data_reg >> {~lane, 3'h0};
      end
      load_word_right_part, store_word_right_part: begin
        size = lsba_size_type'(~lane);
        mask = `LSBA_MASK_FULL << lane;
        wdata = i_req.data_reg << {lane, 3'h0};
      end
      default: begin
        legal = 1'b0;
      end
    endcase
    next_err = i_req.valid && !legal;
    next_bus.valid = i_req.valid && legal;
    next_bus.write = !is_load;
    next_bus.size = size;
    next_bus.addr = ea;
    next_bus.byte_enable_lanes_n = next_bus.valid ? ~mask
                                                  : `LSBA_BE_NONE;
    next_bus.wdata = wdata;
    next_s1_op = (next_bus.valid && is_load) ? i_req.op : op_none;
    next_s1_lane = lane;
    next_s1_hlane = hlane;
    next_s1_dest = i_req.dest;
    next_s1_old = i_reg_old;
  end

  // Issue stage registers.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bus <= '{valid: 1'b0, write: 1'b0, size: size_byte,
                 addr: `LSBA_RST_WORD, byte_enable_lanes_n: `LSBA_BE_NONE,
                 wdata: `LSBA_RST_WORD};
      o_addr_err <= 1'b0;
      s1_op <= op_none;
      s1_lane <= 2'h0;
      s1_hlane <= 2'h0;
      s1_dest <= `LSBA_RST_REG;
      s1_old <= `LSBA_RST_WORD;
    end else begin
      o_bus <= next_bus;
      o_addr_err <= next_err;
      s1_op <= next_s1_op;
      s1_lane <= next_s1_lane;
      s1_hlane <= next_s1_hlane;
      s1_dest <= next_s1_dest;
      s1_old <= next_s1_old;
    end
  end

  // ==========================================================
  // Load alignment stage
  // ==========================================================
  logic [31:0] old_fwd;
  logic [31:0] byte_sh;
  logic [31:0] half_sh;
  logic [31:0] left_sh;
  logic [31:0] right_sh;
  logic [3:0] keep;
  logic [31:0] merged;
  lsba_wb_type next_wb;

  // A partial load right behind a load to the same register merges
  // into the value that the earlier load is just writing back.
  assign old_fwd = (o_wb.valid && o_wb.dest == s1_dest) ? o_wb.data
                                                       : s1_old;

  // Bytes a left or right load keeps from the old register, one flag per lane.
  always_comb begin
    keep = 4'h0;
    if (s1_op == load_word_left_part) begin
      keep = `LSBA_MASK_FULL >> (s1_lane + 2'h1);
      if (s1_lane == 2'h3) begin
        keep = 4'h0;
      end
    end else if (s1_op == load_word_right_part) begin
      keep = ~(`LSBA_MASK_FULL >> s1_lane);
    end
  end

  // Per-lane merge of memory bytes with the old register bytes.
  for (genvar g = 0; g < `LSBA_LANES; g++) begin : g_merge
    assign merged[8*g +: 8] = keep[g] ? old_fwd[8*g +: 8]
                 : (s1_op == load_word_left_part) ? left_sh[8*g +: 8]
                 : right_sh[8*g +: 8];
  end

  // Extension and alignment of the returned word.
  always_comb begin
    byte_sh = i_mem_data >> {s1_lane, 3'h0};
    half_sh = i_mem_data >> {s1_hlane, 3'h0};
    left_sh = i_mem_data << {~s1_lane, 3'h0};
    right_sh = i_mem_data >> {s1_lane, 3'h0};
    next_wb.valid = (s1_op != op_none);
    next_wb.dest = s1_dest;
    next_wb.data = i_mem_data;
    unique case (s1_op)
      load_byte_signed: begin
        next_wb.data = {{24{byte_sh[7]}}, byte_sh[7:0]};
      end
      load_byte_unsigned: begin
        next_wb.data = {24'h0, byte_sh[7:0]};
      end
      load_half_signed: begin
        next_wb.data = {{16{half_sh[15]}}, half_sh[15:0]};
      end
      load_half_unsigned: begin
        next_wb.data = {16'h0, half_sh[15:0]};
      end
      load_word_left_part, load_word_right_part: begin
        next_wb.data = merged;
      end
      default: begin
        next_wb.data = i_mem_data;
      end
    endcase
  end

  // Write-back register, valid two cycles after the request.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wb <= '{valid: 1'b0, dest: `LSBA_RST_REG, data: `LSBA_RST_WORD};
    end else begin
      o_wb <= next_wb;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  // A legal load request in the current cycle.
  sequence load_issued;
    i_req.valid && !i_req.op[3] && legal;
  endsequence

  // Request of a given op, legal.
  sequence op_issued(lsba_op_type op);
    i_req.valid && i_req.op == op && legal;
  endsequence

  ea_sum_a: assert property (
    i_req.valid && legal |=> o_bus.valid &&
      o_bus.addr == $past(i_req.base) +
        {{16{$past(i_req.offset[15])}}, $past(i_req.offset)})
    else $error("effective address wrong");

  bad_pair_a: assert property (
    i_req.valid && !legal |=> o_addr_err && !o_bus.valid &&
      o_bus.byte_enable_lanes_n == 4'hf)
    else $error("illegal access reached bus");

  word_lanes_a: assert property (
    op_issued(load_word_full) |=> o_bus.byte_enable_lanes_n == 4'h0)
    else $error("word access lanes wrong");

  byte_lane_a: assert property (
    i_req.valid && i_req.op == store_byte_op && !big |=>
      o_bus.byte_enable_lanes_n == ~(4'h1 << $past(ofs)))
    else $error("little-endian byte lane wrong");

  mirror_lane_a: assert property (
    i_req.valid && i_req.op == store_byte_op && big |=>
      o_bus.byte_enable_lanes_n == ~(4'h8 >> $past(ofs)))
    else $error("big-endian byte lane wrong");

  user_swap_a: assert property (
    i_req.valid && i_req.op == store_byte_op && i_user_mode &&
      i_reverse_endian_user |=> o_bus.byte_enable_lanes_n ==
      ~($past(i_big_endian) ? 4'h1 << $past(ofs) : 4'h8 >> $past(ofs)))
    else $error("user byte order not reversed");

  load_latency_a: assert property (
    load_issued |-> ##2 o_wb.valid && o_wb.dest == $past(i_req.dest, 2))
    else $error("load result not on time");

  sign_ext_a: assert property (
    op_issued(load_byte_signed) |-> ##2
      o_wb.data[31:8] == {24{o_wb.data[7]}})
    else $error("byte not sign-extended");

  zero_ext_a: assert property (
    op_issued(load_half_unsigned) |-> ##2 o_wb.data[31:16] == 16'h0)
    else $error("half not zero-extended");

  word_pass_a: assert property (
    s1_op == load_word_full |=> o_wb.data == $past(i_mem_data))
    else $error("word load modified");

  left_keep_a: assert property (
    s1_op == load_word_left_part && s1_lane == 2'h0 |=>
      o_wb.data == {$past(i_mem_data[7:0]), $past(old_fwd[23:0])})
    else $error("left load merge wrong");

  store_half_a: assert property (
    op_issued(store_half_op) ##0 (!big && ofs == 2'h0) |=>
      o_bus.wdata[15:0] == $past(i_req.data_reg[15:0]))
    else $error("half store data wrong");

  store_right_a: assert property (
    op_issued(store_word_right_part) ##0 (lane == 2'h1) |=>
      o_bus.wdata[31:8] == $past(i_req.data_reg[23:0]) &&
      o_bus.byte_enable_lanes_n == 4'h1)
    else $error("right store wrong");

  store_left_a: assert property (
    op_issued(store_word_left_part) ##0 (lane == 2'h1) |=>
      o_bus.wdata[15:0] == $past(i_req.data_reg[31:16]) &&
      o_bus.byte_enable_lanes_n == 4'hc)
    else $error("left store wrong");

endmodule

// *** rtl/lsba_defs.svh ***
// Constants of the load/store byte lane alignment datapath.
`ifndef LSBA_DEFS_SVH
`define LSBA_DEFS_SVH
`define LSBA_DATA_W 32
`define LSBA_OFS_W 16
`define LSBA_REG_W 5
`define LSBA_LANES 4
`define LSBA_BE_NONE 4'hf
`define LSBA_BE_ALL 4'h0
`define LSBA_MASK_BYTE 4'h1
`define LSBA_MASK_HALF 4'h3
`define LSBA_MASK_FULL 4'hf
`define LSBA_HALF_SWAP 2'h2
`define LSBA_RST_WORD 32'h0000_0000
`define LSBA_RST_REG 5'h00
`define LSBA_LOAD_LAT 2
`endif

// *** rtl/lsba_pkg.sv ***
// Types shared by the load/store byte lane alignment datapath.
package lsba_pkg;
  // Operation codes of the load/store unit.
  typedef enum logic [3:0] {
    load_byte_signed = 4'h0,
    load_byte_unsigned = 4'h1,
    load_half_signed = 4'h2,
    load_half_unsigned = 4'h3,
    load_word_full = 4'h4,
    load_word_left_part = 4'h5,
    load_word_right_part = 4'h6,
    store_byte_op = 4'h8,
    store_half_op = 4'h9,
    store_word_full = 4'ha,
    store_word_left_part = 4'hb,
    store_word_right_part = 4'hc,
    op_none = 4'hf
  } lsba_op_type;
  // Transfer size, coded as byte count minus one.
  typedef enum logic [1:0] {
    size_byte = 2'h0,
    size_half = 2'h1,
    size_tri = 2'h2,
    size_word = 2'h3
  } lsba_size_type;
  // Request from the pipeline.
  typedef struct packed {
    logic valid;
    lsba_op_type op;
    logic [31:0] base;
    logic [15:0] offset;
    logic [31:0] data_reg;
    logic [4:0] dest;
  } lsba_req_type;
  // Access presented to the memory bus interface.
  typedef struct packed {
    logic valid;
    logic write;
    lsba_size_type size;
    logic [31:0] addr;
    logic [3:0] byte_enable_lanes_n;
    logic [31:0] wdata;
  } lsba_bus_type;
  // Load result for the register file.
  typedef struct packed {
    logic valid;
    logic [4:0] dest;
    logic [31:0] data;
  } lsba_wb_type;
endpackage
